// >>> ctp_pkg.sv
// Constants, state codes and register map for the transmit and interrupt block
package ctp_pkg;

	localparam int NBUF    = 15;
	localparam int AW      = 8;
	localparam int DW      = 16;
	localparam int BUSY_B  = 0;
	localparam int TX_B    = 3;
	localparam int ST_MSB  = 3;
	localparam int PRI_LSB = 4;
	localparam int PRI_MSB = 7;
	localparam int ERR_B   = 15;
	localparam int FLAG_B  = 4;

	typedef logic [3:0] ctp_code_t;
	typedef logic [3:0] ctp_idx_t;

	// Buffer condition field codes
	localparam ctp_code_t ST_RX_OFF     = 4'h0;
	localparam ctp_code_t ST_RX_READY   = 4'h2;
	localparam ctp_code_t ST_RX_FULL    = 4'h4;
	localparam ctp_code_t ST_RX_OVR     = 4'h6;
	localparam ctp_code_t ST_TX_IDLE    = 4'h8;
	localparam ctp_code_t ST_AWAIT      = 4'hA;
	localparam ctp_code_t ST_SINGLE     = 4'hC;
	localparam ctp_code_t ST_SEND_AWAIT = 4'hE;

	// Register word addresses
	localparam logic [AW-1:0] A_BUF_LAST  = 8'h0E;
	localparam logic [AW-1:0] A_IRQ_EN    = 8'h10;
	localparam logic [AW-1:0] A_IRQ_PEND  = 8'h11;
	localparam logic [AW-1:0] A_IRQ_CLR   = 8'h12;
	localparam logic [AW-1:0] A_CODE_EN   = 8'h13;
	localparam logic [AW-1:0] A_STAT_PEND = 8'h14;
	localparam logic [AW-1:0] A_ERR_DIAG  = 8'h15;

	localparam logic [DW-1:0] IEN_RST = 16'h0000;
	localparam logic [DW-1:0] CEN_RST = 16'hFFFF;

	typedef enum logic [1:0] {PH_IDLE, PH_SEND, PH_TAIL, PH_HOLD} ctp_phase_e;

	typedef struct packed {
		logic [NBUF-1:0][3:0] st;
		logic [NBUF-1:0][3:0] arbitration_rank;
		logic [DW-1:0]        ien;
		logic [DW-1:0]        pend;
		logic [DW-1:0]        cen;
		logic [DW-1:0]        diag;
		logic                 cv;
		logic                 nv;
		ctp_idx_t             ci;
		ctp_idx_t             ni;
		ctp_phase_e           ph;
		logic                 irq;
		logic                 wake;
		logic [3:0]           code;
		logic [DW-1:0]        rdata;
	} ctp_state_s;

	localparam ctp_state_s STATE_RST = '{st: '0, arbitration_rank: '0, ien: IEN_RST,
		pend: '0, cen: CEN_RST, diag: '0, cv: 1'b0, nv: 1'b0, ci: '0,
		ni: '0, ph: PH_IDLE, irq: 1'b0, wake: 1'b0, code: '0, rdata: '0};

endpackage : ctp_pkg

// >>> ctp_can_tx_irq.sv
// Transmit scheduling, buffer condition machine and interrupt logic
// How it works
// R1: Next frame request is up at frame end, so arbitration follows at once.
// R2: Rank is sender rank code on top, buffer index 0..14 below.
// R3: Smallest rank among requesting buffers is chosen for sending.
// R4: Equal ranks go to the lower buffer index.
// R5: Software sets transmit-idle first and waits while the buffer is busy.
// R6: Software loads identifier and data before it asks to send.
// R7: Writing single-send or send-then-await-remote raises a send request.
// R8: Await-remote buffer sends its data on a matching remote frame.
// R9: Single-send buffer turns busy when it is chosen as next frame.
// R10: Sent data frame gives transmit-idle, sent remote frame receive-armed.
// R11: Send-then-await-remote shows busy while sending, then awaits remote.
// R12: Remote frame moves await-remote back to send-then-await-remote.
// R13: Writing await-remote only waits; nothing is sent until a remote frame.
// R14: One interrupt line for all causes, plus a receive wake-up pulse.
// R15: Data frame receive and data frame send completion raise buffer flags.
// R16: Remote answer done and remote-triggered scheduling raise buffer flags.
// R17: Bus error sets the error flag and the error diagnostic bits.
// R18: Pending flags are read only; software clears them by writing ones.
// R19: Every cause sets its pending flag; each has its own enable bit.
// R20: Top enabled pending cause with code enable shows as a 4-bit code.
// R21: No request 0/0, error 1/0, buffer n gives 1 and n plus one.
// R22: A buffer is a transmit buffer whenever its top condition bit is set.
// R23: Next buffer is chosen from the CRC field on; two may be busy.
// R24: A chosen buffer displaced by a better one drops busy and goes back to single-send or send-then-await-remote.
// R25: A failed frame stays pending and is sent again until done or cancelled.
// R26: Error cause ranks above buffers, lower buffers above higher ones.
// R27: Selection scans all requests at once and reruns after a failed frame.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module ctp_can_tx_irq
	import ctp_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic      [DW-1:0] rdata,
	input  wire logic          eng_frame_start,
	input  wire logic          eng_crc_start,
	input  wire logic          eng_tx_ok,
	input  wire logic          eng_tx_remote,
	input  wire logic          eng_tx_fail,
	input  wire logic          eng_resume,
	input  wire logic          eng_rx_data,
	input  wire logic          eng_rx_remote,
	input  wire logic [3:0]    eng_rx_idx,
	input  wire logic          eng_bus_err,
	input  wire logic [DW-1:0] eng_err_bits,
	output logic               tx_req,
	output logic      [3:0]    tx_buf,
	output logic               irq,
	output logic               wake_rx
);

	ctp_state_s s_reg;
	ctp_state_s s_next;

	// Combined arbitration rank of one buffer
	function automatic logic [7:0] rank(input logic [3:0] p,
		input ctp_idx_t i);
		return {p, i}; // [R2]
	endfunction : rank

	// Buffer holds a send request that is not yet scheduled
	function automatic logic is_req(input logic [3:0] c);
		return c[TX_B] && (c == ST_SINGLE || c == ST_SEND_AWAIT); // [R22]
	endfunction : is_req

	// One-pass scan for the best request; strict compare keeps low index
	function automatic logic [4:0] pick(input logic [NBUF-1:0][3:0] st,
		input logic [NBUF-1:0][3:0] arbitration_rank);
		logic       f;
		ctp_idx_t   b;
		logic [7:0] r;
		f = 1'b0;
		b = '0;
		r = '0;
		for (int i = 0; i < NBUF; i++) begin
			if (is_req(st[i]) && (!f || rank(arbitration_rank[i], 4'(i)) < r)) begin // [R3] [R4] [R27]
				f = 1'b1;
				b = 4'(i);
				r = rank(arbitration_rank[i], 4'(i));
			end
		end
		return {f, b};
	endfunction : pick

	// Code of the top enabled cause: error first, then lowest buffer
	function automatic logic [3:0] irq_code(input logic [DW-1:0] a);
		logic [3:0] c;
		c = '0;
		for (int i = NBUF - 1; i >= 0; i--) begin
			if (a[i]) begin
				c = 4'(i + 1); // [R21]
			end
		end
		if (a[ERR_B]) begin
			c = '0; // [R26]
		end
		return c;
	endfunction : irq_code

	// Next state of the whole block
	always_comb begin
		ctp_idx_t      b;
		ctp_idx_t      ci;
		logic [DW-1:0] setv;
		logic [DW-1:0] clrv;
		logic [DW-1:0] act;
		logic [4:0]    sel;
		b = addr[3:0];
		ci = s_reg.ci;
		setv = '0;
		clrv = '0;
		act = '0;
		sel = '0;
		s_next = s_reg;
		s_next.wake = 1'b0;
		s_next.rdata = '0;

		// Software writes; the busy bit ignores wdata and every buffer write clears it
		if (wr) begin
			if (addr <= A_BUF_LAST) begin
				if (!s_reg.st[b][BUSY_B]) begin
					s_next.arbitration_rank[b] = wdata[PRI_MSB:PRI_LSB];
				end
				s_next.st[b] = {wdata[ST_MSB:BUSY_B+1], 1'b0}; // [R7] [R13]
			end
			case (addr)
				A_IRQ_EN: begin
					s_next.ien = wdata; // [R19]
				end
				A_IRQ_CLR: begin
					clrv = wdata; // [R18]
				end
				A_CODE_EN: begin
					s_next.cen = wdata;
				end
				A_ERR_DIAG: begin
					s_next.diag = s_reg.diag & ~wdata;
				end
				default: begin
				end
			endcase
		end

		// Software moved a busy buffer away: drop its scheduling slot
		if (s_reg.nv && !s_next.st[s_reg.ni][BUSY_B]) begin
			s_next.nv = 1'b0;
		end
		if (s_reg.cv && !s_next.st[ci][BUSY_B]) begin
			s_next.cv = 1'b0;
		end

		// Link progress
		case (s_reg.ph)
			PH_IDLE, PH_TAIL: begin
				if (eng_frame_start && s_next.nv) begin
					s_next.cv = 1'b1;
					s_next.ci = s_next.ni;
					s_next.nv = 1'b0;
					s_next.ph = PH_SEND;
				end else if (eng_tx_ok) begin
					s_next.ph = PH_IDLE;
				end
			end
			PH_SEND: begin
				if (eng_tx_fail) begin
					s_next.ph = PH_HOLD;
				end else if (eng_crc_start) begin
					s_next.ph = PH_TAIL; // [R23]
				end
			end
			PH_HOLD: begin
				if (eng_resume) begin
					s_next.ph = PH_IDLE;
				end
			end
			default: begin
				s_next.ph = PH_IDLE;
			end
		endcase

		// Completed frame updates the sent buffer
		if (eng_tx_ok && s_next.cv && s_reg.ph != PH_HOLD) begin
			if (s_next.st[ci] == (ST_SEND_AWAIT | 4'h1)) begin
				s_next.st[ci] = ST_AWAIT; // [R11]
				setv[ci] = 1'b1; // [R16]
			end else if (eng_tx_remote) begin
				s_next.st[ci] = ST_RX_READY; // [R10]
			end else begin
				s_next.st[ci] = ST_TX_IDLE; // [R10]
				setv[ci] = 1'b1; // [R15]
			end
			s_next.cv = 1'b0;
			if (s_reg.ph == PH_SEND) begin
				s_next.ph = PH_IDLE;
			end
		end

		// Failed frame is rescheduled once the bus is free again
		if (s_reg.ph == PH_HOLD && eng_resume && s_next.cv) begin // [R25] [R27]
			if (!s_next.nv || rank(s_next.arbitration_rank[ci], ci)
				< rank(s_next.arbitration_rank[s_next.ni], s_next.ni)) begin
				if (s_next.nv) begin
					s_next.st[s_next.ni][BUSY_B] = 1'b0; // [R24]
				end
				s_next.nv = 1'b1;
				s_next.ni = ci;
			end else begin
				s_next.st[ci][BUSY_B] = 1'b0;
			end
			s_next.cv = 1'b0;
		end

		// Remote frame answers an await-remote buffer
		if (eng_rx_remote && eng_rx_idx < 4'(NBUF)
			&& s_next.st[eng_rx_idx] == ST_AWAIT) begin
			s_next.st[eng_rx_idx] = ST_SEND_AWAIT; // [R8] [R12]
			setv[eng_rx_idx] = 1'b1; // [R16]
		end

		// Data frame lands in a receive-armed or full buffer
		if (eng_rx_data && eng_rx_idx < 4'(NBUF)) begin
			if (s_next.st[eng_rx_idx] == ST_RX_READY) begin
				s_next.st[eng_rx_idx] = ST_RX_FULL;
				setv[eng_rx_idx] = 1'b1; // [R15]
				s_next.wake = 1'b1; // [R14]
			end else if (s_next.st[eng_rx_idx] == ST_RX_FULL) begin
				s_next.st[eng_rx_idx] = ST_RX_OVR;
				setv[eng_rx_idx] = 1'b1; // [R15]
				s_next.wake = 1'b1; // [R14]
			end
		end

		// Bus error; a new error bit wins over a same-cycle clear
		if (eng_bus_err) begin
			setv[ERR_B] = 1'b1; // [R17]
			s_next.diag = s_next.diag | eng_err_bits; // [R17]
		end

		// Pick next frame while idle or from the CRC field on, never during PH_SEND
		if (s_next.ph == PH_IDLE || s_next.ph == PH_TAIL) begin
			sel = pick(s_next.st, s_next.arbitration_rank);
			if (sel[4] && (!s_next.nv
				|| rank(s_next.arbitration_rank[sel[3:0]], sel[3:0])
				< rank(s_next.arbitration_rank[s_next.ni], s_next.ni))) begin
				if (s_next.nv) begin
					s_next.st[s_next.ni][BUSY_B] = 1'b0; // [R24]
				end
				s_next.st[sel[3:0]][BUSY_B] = 1'b1; // [R9]
				s_next.nv = 1'b1;
				s_next.ni = sel[3:0];
			end
		end

		// Pending flags: set wins over clear
		s_next.pend = (s_reg.pend & ~clrv) | setv; // [R18] [R19]
		act = s_next.pend & s_next.ien;
		s_next.irq = |act; // [R14]
		s_next.code = irq_code(act & s_next.cen); // [R20]

		// Read data stands in the following cycle only
		if (rd) begin
			if (addr <= A_BUF_LAST) begin
				s_next.rdata = {8'h00, s_reg.arbitration_rank[b], s_reg.st[b]};
			end else begin
				case (addr)
					A_IRQ_EN: begin
						s_next.rdata = s_reg.ien;
					end
					A_IRQ_PEND: begin
						s_next.rdata = s_reg.pend;
					end
					A_CODE_EN: begin
						s_next.rdata = s_reg.cen;
					end
					A_STAT_PEND: begin
						s_next.rdata = 16'h0000;
						s_next.rdata[FLAG_B] = s_reg.irq; // [R21]
						s_next.rdata[3:0] = s_reg.code;
					end
					A_ERR_DIAG: begin
						s_next.rdata = s_reg.diag;
					end
					default: begin
						s_next.rdata = '0;
					end
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Request is a level so the engine arbitrates right after a frame
	assign tx_req = s_reg.nv; // [R1]
	assign tx_buf = s_reg.ni;
	assign irq = s_reg.irq; // [R14]
	assign wake_rx = s_reg.wake;
	assign rdata = s_reg.rdata;

	// Checks on the block's own behaviour
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);

	logic [4:0] best;
	logic       sel_ph;
	logic [DW-1:0] act_c;
	assign best = pick(s_reg.st, s_reg.arbitration_rank);
	assign sel_ph = s_reg.ph == PH_IDLE || s_reg.ph == PH_TAIL;
	assign act_c = s_reg.pend & s_reg.ien & s_reg.cen;

	sequence sq_single_ok;
		eng_tx_ok && s_reg.cv && s_reg.ph == PH_TAIL && !wr
			&& s_reg.st[s_reg.ci] == (ST_SINGLE | 4'h1);
	endsequence

	sequence sq_await_ok;
		eng_tx_ok && s_reg.cv && s_reg.ph == PH_TAIL && !wr
			&& s_reg.st[s_reg.ci] == (ST_SEND_AWAIT | 4'h1);
	endsequence

	sched_busy_a: assert property (tx_req |-> s_reg.st[tx_buf][BUSY_B]) // [R9]
		else $error("scheduled buffer not busy");

	best_rank_a: assert property (sel_ph && s_reg.nv && best[4] // [R3]
		|-> rank(s_reg.arbitration_rank[best[3:0]], best[3:0])
		> rank(s_reg.arbitration_rank[s_reg.ni], s_reg.ni))
		else $error("better request left waiting");

	data_done_a: assert property (sq_single_ok ##0 !eng_tx_remote // [R10]
		|=> s_reg.st[$past(s_reg.ci)] == ST_TX_IDLE
		&& s_reg.pend[$past(s_reg.ci)])
		else $error("data frame did not end in transmit idle");

	remote_done_a: assert property (sq_single_ok ##0 eng_tx_remote // [R10]
		|=> s_reg.st[$past(s_reg.ci)] == ST_RX_READY)
		else $error("remote frame did not arm receive");

	await_after_a: assert property (sq_await_ok // [R11]
		|=> s_reg.st[$past(s_reg.ci)] == ST_AWAIT
		&& s_reg.pend[$past(s_reg.ci)])
		else $error("answer did not return to await remote");

	remote_rx_a: assert property (eng_rx_remote && !wr // [R12]
		&& eng_rx_idx < 4'(NBUF) && s_reg.st[eng_rx_idx] == ST_AWAIT
		|=> s_reg.st[$past(eng_rx_idx)][ST_MSB:BUSY_B+1] == 3'h7
		&& s_reg.pend[$past(eng_rx_idx)])
		else $error("remote frame did not trigger answer");

	pend_hold_a: assert property (!(wr && addr == A_IRQ_CLR) // [R18]
		|=> (s_reg.pend & $past(s_reg.pend)) == $past(s_reg.pend))
		else $error("pending flag lost without clear");

	err_code_a: assert property (act_c[ERR_B] // [R21]
		|-> s_reg.code == 4'h0 && s_reg.irq)
		else $error("error cause not coded first");

	buf0_code_a: assert property (act_c[0] && !act_c[ERR_B] // [R26]
		|-> s_reg.code == 4'h1)
		else $error("buffer zero code wrong");

	err_flag_a: assert property (eng_bus_err // [R17]
		|=> s_reg.pend[ERR_B] && ((s_reg.diag & $past(eng_err_bits))
		== $past(eng_err_bits)))
		else $error("bus error not recorded");

	crc_gate_a: assert property (s_reg.ph == PH_SEND && !s_reg.nv // [R23]
		&& !eng_crc_start && !eng_tx_ok && !eng_tx_fail |=> !s_reg.nv)
		else $error("next frame chosen before CRC field");

	retry_a: assert property (eng_tx_fail && s_reg.cv // [R25]
		&& s_reg.ph == PH_SEND && !wr
		|=> s_reg.st[$past(s_reg.ci)][BUSY_B])
		else $error("failed buffer left busy state");

	wake_a: assert property (eng_rx_data && !wr // [R14]
		&& eng_rx_idx < 4'(NBUF) && s_reg.st[eng_rx_idx] == ST_RX_READY
		|=> wake_rx ##1 !wake_rx)
		else $error("wake pulse missing");

endmodule : ctp_can_tx_irq

// >>> ctp_eng_model.sv
// Far-side bus engine model: sends scheduled frames, fails each frame started while fail is high
`timescale 1ns/100ps
module ctp_eng_model
	import ctp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       en,
	input  wire logic       fail,
	input  wire logic       tx_req,
	input  wire logic [3:0] tx_buf,
	output logic            eng_frame_start,
	output logic            eng_crc_start,
	output logic            eng_tx_ok,
	output logic            eng_tx_fail,
	output logic            eng_resume,
	output logic [7:0]      n_ok,
	output logic [3:0]      last
);
	logic       busy;
	logic       bad;
	logic [2:0] cnt;
	logic [3:0] cur;

	// One frame at a time; the fail choice is latched at frame start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{eng_frame_start, eng_crc_start, eng_tx_ok} <= '0;
			{eng_tx_fail, eng_resume, busy, bad} <= '0;
			{cnt, cur, n_ok, last} <= '0;
		end else begin
			{eng_frame_start, eng_crc_start, eng_tx_ok} <= '0;
			{eng_tx_fail, eng_resume} <= '0;
			if (!busy && en && tx_req) begin
				eng_frame_start <= 1'b1;
				busy <= 1'b1;
				bad <= fail;
				cnt <= 3'h0;
				cur <= tx_buf;
			end else if (busy) begin
				cnt <= cnt + 3'h1;
				if (cnt == 3'h1) begin
					eng_crc_start <= !bad;
					eng_tx_fail <= bad;
				end
				// Next frame may start one cycle after this end
				if (cnt == 3'h4) begin
					busy <= 1'b0;
					eng_resume <= bad;
					eng_tx_ok <= !bad;
					n_ok <= bad ? n_ok : n_ok + 8'h01;
					last <= bad ? last : cur;
				end
			end
		end
	end
endmodule : ctp_eng_model

// >>> ctp_can_tx_irq_tb.sv
// Self-checking bench for transmit scheduling and interrupt logic
`timescale 1ns/100ps
module ctp_can_tx_irq_tb
	import ctp_pkg::*;
;
	logic          clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wdata = '0, eng_err_bits = '0, rdata;
	logic          eng_tx_remote = 1'b0, eng_rx_data = 1'b0, en = 1'b0;
	logic          eng_rx_remote = 1'b0, eng_bus_err = 1'b0, fail = 1'b0;
	logic          eng_frame_start, eng_crc_start, eng_tx_ok, eng_tx_fail;
	logic          eng_resume, tx_req, irq, wake_rx;
	logic [3:0]    eng_rx_idx = 4'h0, tx_buf, last;
	logic [7:0]    n_ok;
	int            num_errors = 0, n_compared = 0, sent = 0;

	ctp_can_tx_irq dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
		.eng_frame_start, .eng_crc_start, .eng_tx_ok, .eng_tx_remote,
		.eng_tx_fail, .eng_resume, .eng_rx_data, .eng_rx_remote,
		.eng_rx_idx, .eng_bus_err, .eng_err_bits, .tx_req, .tx_buf, .irq,
		.wake_rx);
	ctp_eng_model mdl (.clk, .rst, .en, .fail, .tx_req, .tx_buf,
		.eng_frame_start, .eng_crc_start, .eng_tx_ok, .eng_tx_fail,
		.eng_resume, .n_ok, .last);

	// 4 ns clock
	always #2 clk = ~clk;

	// Verdict and end of run
	task automatic stop_test();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Register bus cycles; read data sampled in the cycle after the strobe
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd_chk

	// Software parks the buffer idle before loading the new code
	task automatic arm(input logic [3:0] n, input logic [7:0] v);
		wr_reg({4'h0, n}, 16'h0008);
		wr_reg({4'h0, n}, {8'h00, v});
		#1;
	endtask : arm

	task automatic pulse_rx(input logic data, input logic [3:0] i);
		@(posedge clk);
		eng_rx_data <= data;
		eng_rx_remote <= !data;
		eng_rx_idx <= i;
		@(posedge clk);
		eng_rx_data <= 1'b0;
		eng_rx_remote <= 1'b0;
		#1;
	endtask : pulse_rx

	// Bounded wait for the next good frame, then its buffer is checked
	task automatic wait_ok(input logic [3:0] b);
		sent++;
		for (int i = 0; i < 300 && n_ok != sent[7:0]; i++) @(posedge clk);
		@(posedge clk);
		#1;
		chk({8'h00, n_ok}, sent[15:0]);
		if (n_ok !== sent[7:0]) stop_test();
		chk({12'h000, last}, {12'h000, b});
	endtask : wait_ok

	task automatic t_reset();
		chk({14'h0000, tx_req, irq}, 16'h0000);
		rd_chk(A_IRQ_EN, IEN_RST);
		rd_chk(A_CODE_EN, CEN_RST);
		rd_chk(A_STAT_PEND, 16'h0000);
		rd_chk(8'h0F, 16'h0000);
	endtask : t_reset

	// Ranking, displacement, cancel and a back-to-back stream
	task automatic t_prio();
		arm(4'h0, 8'hEC);
		arm(4'hE, 8'h0C);
		chk({12'h000, tx_buf}, 16'h000E);
		rd_chk(8'h00, 16'h00EC);
		rd_chk(8'h0E, 16'h000D);
		arm(4'h3, 8'h0C);
		arm(4'h1, 8'h0C);
		chk({12'h000, tx_buf}, 16'h0001);
		wr_reg(8'h01, 16'h0008);
		rd_chk(8'h01, 16'h0008);
		chk({11'h000, tx_req, tx_buf}, 16'h0013);
		@(posedge clk);
		en <= 1'b1;
		wait_ok(4'h3);
		wait_ok(4'hE);
		wait_ok(4'h0);
		rd_chk(A_IRQ_PEND, 16'h4009);
		chk({15'h0000, irq}, 16'h0000);
		wr_reg(A_IRQ_CLR, 16'hFFFF);
	endtask : t_prio

	task automatic t_irq();
		wr_reg(A_IRQ_EN, 16'h8004);
		arm(4'h2, 8'h0C);
		wait_ok(4'h2);
		rd_chk(8'h02, 16'h0008);
		chk({15'h0000, irq}, 16'h0001);
		rd_chk(A_STAT_PEND, 16'h0013);
		wr_reg(A_IRQ_PEND, 16'h0000);
		rd_chk(A_IRQ_PEND, 16'h0004);
		@(posedge clk);
		eng_bus_err <= 1'b1;
		eng_err_bits <= 16'h0021;
		@(posedge clk);
		eng_bus_err <= 1'b0;
		rd_chk(A_ERR_DIAG, 16'h0021);
		rd_chk(A_IRQ_PEND, 16'h8004);
		rd_chk(A_STAT_PEND, 16'h0010);
		wr_reg(A_CODE_EN, 16'h0004);
		rd_chk(A_STAT_PEND, 16'h0013);
		wr_reg(A_CODE_EN, 16'hFFFF);
		wr_reg(A_IRQ_CLR, 16'h8004);
		rd_chk(A_STAT_PEND, 16'h0000);
	endtask : t_irq

	// Remote frame sent, then data frames received into the same buffer
	task automatic t_remote();
		@(posedge clk);
		eng_tx_remote <= 1'b1;
		arm(4'h5, 8'h0C);
		wait_ok(4'h5);
		@(posedge clk);
		eng_tx_remote <= 1'b0;
		rd_chk(8'h05, 16'h0002);
		pulse_rx(1'b1, 4'h5);
		chk({15'h0000, wake_rx}, 16'h0001);
		rd_chk(8'h05, 16'h0004);
		pulse_rx(1'b1, 4'h5);
		rd_chk(8'h05, 16'h0006);
		rd_chk(A_IRQ_PEND, 16'h0020);
		wr_reg(A_IRQ_CLR, 16'h0020);
	endtask : t_remote

	task automatic t_await();
		arm(4'h6, 8'h0A);
		rd_chk(8'h06, 16'h000A);
		chk({15'h0000, tx_req}, 16'h0000);
		pulse_rx(1'b0, 4'h6);
		chk({11'h000, tx_req, tx_buf}, 16'h0016);
		rd_chk(A_IRQ_PEND, 16'h0040);
		wr_reg(A_IRQ_CLR, 16'h0040);
		wait_ok(4'h6);
		rd_chk(8'h06, 16'h000A);
		rd_chk(A_IRQ_PEND, 16'h0040);
		@(posedge clk);
		en <= 1'b0;
		arm(4'h7, 8'h0E);
		chk({11'h000, tx_req, tx_buf}, 16'h0017);
		rd_chk(8'h07, 16'h000F);
		@(posedge clk);
		en <= 1'b1;
		wait_ok(4'h7);
		rd_chk(8'h07, 16'h000A);
		wr_reg(A_IRQ_CLR, 16'hFFFF);
	endtask : t_await

	// A failed frame stays busy and is sent again after the resume
	task automatic t_fail();
		@(posedge clk);
		fail <= 1'b1;
		arm(4'h4, 8'h0C);
		for (int i = 0; i < 50 && eng_tx_fail !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		fail <= 1'b0;
		chk({15'h0000, eng_tx_fail}, 16'h0001);
		if (eng_tx_fail !== 1'b1) stop_test();
		rd_chk(8'h04, 16'h000D);
		wait_ok(4'h4);
		rd_chk(8'h04, 16'h0008);
	endtask : t_fail

	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_prio();
		t_irq();
		t_remote();
		t_await();
		t_fail();
		stop_test();
	end
endmodule : ctp_can_tx_irq_tb
